/* include/osl_defs.svh */
// Constants for the lock and state save/restore block
`ifndef OSL_DEFS_SVH
`define OSL_DEFS_SVH
// Register byte offsets on the debug APB
`define OSL_BANK_BASE 12'h000
`define OSL_KEY_OFF 12'h300
`define OSL_STAT_OFF 12'h304
`define OSL_SSR_OFF 12'h308
// Lock key
`define OSL_KEY 32'hc5acce55
// Status fields
`define OSL_ST_PRESENT 0
`define OSL_ST_LOCKED 1
`define OSL_ST_WIDE 2
// Sequence geometry
`define OSL_SEQ_LEN 5'h16
`define OSL_PTR_START 5'h00
`define OSL_PTR_FIRST 5'h01
`define OSL_PTR_END 5'h17
`define OSL_PTR_STEP 5'h01
// Bank indexes in sequence order (index = position - 1)
`define OSL_IDX_BVR0 5'h0f
`define OSL_IDX_DEBUG_STATUS_CONTROL 5'h11
// Status/control: bits software may write, and flag bits a restore may load
`define OSL_DEBUG_STATUS_CONTROL_WMASK 32'h0000c000
`define OSL_DEBUG_STATUS_CONTROL_RMASK 32'h6c000000
`define OSL_FULL_MASK 32'hffffffff
`define OSL_ZERO 32'h00000000
`endif

/* include/osl_pkg.sv */
// Types shared by the lock and save/restore block
package osl_pkg;
    // One write into the debug register bank
    typedef struct packed {
        logic en;
        logic restore;
        logic [4:0] idx;
        logic [31:0] data;
    } osl_wr_t;
    // One APB access as seen in its access phase
    typedef struct packed {
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } osl_apb_t;
    // Decoded target of an access
    typedef enum logic [2:0] {
        OSL_T_BANK = 3'b000,
        OSL_T_KEY = 3'b001,
        OSL_T_STAT = 3'b010,
        OSL_T_SSR = 3'b011,
        OSL_T_NONE = 3'b100
    } osl_tgt_t;
endpackage

/* design/osl_bank.sv */
// Core power domain debug register bank, indexed in save/restore order
`timescale 1ns/100ps
`default_nettype none
module osl_bank
    import osl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Write request
    input wire osl_wr_t wr,
    // Read port
    input wire logic [4:0] rd_idx,
    output logic [31:0] rd_data,
    // Live processor flags shown in status/control
    input wire logic [31:0] debug_status_control_flags
);
`include "osl_defs.svh"

    logic [31:0] mem_ff [0:21]; // Register storage
    logic [31:0] nxt_mem [0:21]; // Next storage
    logic [31:0] wmask; // Bits this write may change
    logic [31:0] dmask; // Status/control bits software owns

    // Restore also loads the transfer-mode and status pairs
    always_comb begin
        dmask = `OSL_DEBUG_STATUS_CONTROL_WMASK | (wr.restore ? `OSL_DEBUG_STATUS_CONTROL_RMASK : `OSL_ZERO);
        wmask = (wr.idx == `OSL_IDX_DEBUG_STATUS_CONTROL) ? dmask : `OSL_FULL_MASK;
        for (int i = 0; i < 22; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr.en && wr.idx < `OSL_SEQ_LEN) begin
            nxt_mem[wr.idx] = (mem_ff[wr.idx] & ~wmask) | (wr.data & wmask);
        end
    end

    // Storage registers, cleared on reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < 22; i++) begin
            if (reset) begin
                mem_ff[i] <= `OSL_ZERO;
            end else begin
                mem_ff[i] <= nxt_mem[i];
            end
        end
    end

    // Read-only flags of status/control show live state, not the saved copy
    always_comb begin
        if (rd_idx >= `OSL_SEQ_LEN) begin
            rd_data = `OSL_ZERO;
        end else if (rd_idx == `OSL_IDX_DEBUG_STATUS_CONTROL) begin
            rd_data = (mem_ff[rd_idx] & (`OSL_DEBUG_STATUS_CONTROL_WMASK | `OSL_DEBUG_STATUS_CONTROL_RMASK))
                | (debug_status_control_flags & ~(`OSL_DEBUG_STATUS_CONTROL_WMASK | `OSL_DEBUG_STATUS_CONTROL_RMASK));
        end else begin
            rd_data = mem_ff[rd_idx];
        end
    end
endmodule
`default_nettype wire

/* design/osl_lock.sv */
// Debug lock, lock status and state save/restore port on the debug APB
`timescale 1ns/100ps
`default_nettype none
module osl_lock
    import osl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Lock strap pin
    input wire logic lock_init_strap,
    // Debug APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor side
    input wire logic [31:0] debug_status_control_flags,
    output logic lock_set
);
`include "osl_defs.svh"

    logic strap_meta_ff; // First synchroniser stage
    logic strap_sync_ff; // Second synchroniser stage
    logic lock_ff; // Lock state
    logic nxt_lock;
    logic [4:0] ptr_ff; // Sequence pointer, 0 = length not read yet
    logic [4:0] nxt_ptr;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    osl_apb_t req; // Current access
    osl_tgt_t tgt; // Decoded target
    osl_wr_t wr; // Write into the bank
    logic [4:0] rd_idx; // Bank read index
    logic [31:0] rd_data; // Bank read data
    logic act; // Access commits this cycle
    logic [31:0] status; // Lock status word

    // Strap comes from a pin, so it is synchronised before use
    always_ff @(posedge clk) begin
        strap_meta_ff <= lock_init_strap;
        strap_sync_ff <= strap_meta_ff;
    end

    // Address decode; bank words sit at their index times four
    always_comb begin
        req.write = pwrite;
        req.addr = paddr;
        req.wdata = pwdata;
        act = psel && penable && !pready_ff;
        if (req.addr == `OSL_KEY_OFF) begin
            tgt = OSL_T_KEY;
        end else if (req.addr == `OSL_STAT_OFF) begin
            tgt = OSL_T_STAT;
        end else if (req.addr == `OSL_SSR_OFF) begin
            tgt = OSL_T_SSR;
        end else if (req.addr[1:0] == 2'h0 && req.addr[11:2] < {5'h00, `OSL_SEQ_LEN}) begin
            tgt = OSL_T_BANK;
        end else begin
            tgt = OSL_T_NONE;
        end
    end

    // Status word: present, lock, zero for wide-access bit and above
    always_comb begin
        status = `OSL_ZERO;
        status[`OSL_ST_PRESENT] = 1'b1;
        status[`OSL_ST_LOCKED] = lock_ff;
        status[`OSL_ST_WIDE] = 1'b0;
    end

    // Bank is indexed in save order: WCR1,WCR0,WVR1,WVR0,BCR5..0,BVR5..0,
    // then TRANSMIT_DATA_TRANSFER,DEBUG_STATUS_CONTROL,RECEIVE_DATA_TRANSFER,STATE_CACHE_CONTROL,VECTOR_CATCH,FAULT_ADDRESS_CAPTURE, so the pointer maps directly
    always_comb begin
        if (tgt == OSL_T_SSR) begin
            rd_idx = ptr_ff - `OSL_PTR_FIRST;
        end else begin
            rd_idx = req.addr[6:2];
        end
        wr.en = 1'b0;
        wr.restore = 1'b0;
        wr.idx = rd_idx;
        wr.data = req.wdata;
        if (act && req.write) begin
            if (tgt == OSL_T_BANK && !lock_ff) begin
                wr.en = 1'b1;
            end else if (tgt == OSL_T_SSR && ptr_ff != `OSL_PTR_START
                && ptr_ff != `OSL_PTR_END) begin
                wr.en = 1'b1;
                wr.restore = 1'b1;
            end
        end
    end

    // Access phase: one wait state, then response with data and error
    always_comb begin
        nxt_lock = lock_ff;
        nxt_ptr = ptr_ff;
        nxt_prdata = `OSL_ZERO;
        nxt_pready = act;
        nxt_pslverr = 1'b0;
        if (act) begin
            case (tgt)
                OSL_T_KEY: begin
                    if (req.write) begin
                        if (req.wdata == `OSL_KEY) begin
                            nxt_lock = 1'b1;
                            nxt_ptr = `OSL_PTR_START;
                        end else begin
                            nxt_lock = 1'b0;
                        end
                    end
                end
                OSL_T_STAT: begin
                    if (!req.write) begin
                        nxt_prdata = status;
                    end
                end
                OSL_T_SSR: begin
                    // A write before the length read is ignored
                    if (ptr_ff == `OSL_PTR_START) begin
                        if (!req.write) begin
                            nxt_prdata = {27'h0000000, `OSL_SEQ_LEN};
                            nxt_ptr = `OSL_PTR_FIRST;
                        end
                    end else if (ptr_ff != `OSL_PTR_END) begin
                        if (!req.write) begin
                            nxt_prdata = rd_data;
                        end
                        nxt_ptr = ptr_ff + `OSL_PTR_STEP;
                    end
                end
                OSL_T_BANK: begin
                    if (lock_ff) begin
                        nxt_pslverr = 1'b1;
                    end else if (!req.write) begin
                        nxt_prdata = rd_data;
                    end
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end
    end

    // Registers; lock comes from the synchronised strap on reset
    always_ff @(posedge clk) begin
        if (reset) begin
            lock_ff <= strap_sync_ff;
            ptr_ff <= `OSL_PTR_START;
            prdata_ff <= `OSL_ZERO;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            lock_ff <= nxt_lock;
            ptr_ff <= nxt_ptr;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Register bank of core-domain debug registers
    osl_bank u_bank (
        .clk(clk),
        .reset(reset),
        .wr(wr),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .debug_status_control_flags(debug_status_control_flags)
    );

    // Outputs straight from flip-flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign lock_set = lock_ff;
endmodule
`default_nettype wire

/* testbench/osl_lock_chk.sv */
// Port checker for the lock and save/restore block
`timescale 1ns/100ps
`default_nettype none
`include "osl_defs.svh"
module osl_lock_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Strap and APB slave
    input wire logic lock_init_strap,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Processor side
    input wire logic [31:0] debug_status_control_flags,
    input wire logic lock_set
);
    // First access cycle, where the request is committed
    wire logic take = psel && penable && !pready;
    // Commit of a write to the key register
    wire logic key_wr = take && pwrite && paddr == `OSL_KEY_OFF;
    // Bank window; unaligned ones fail anyway
    wire logic bank = paddr < 12'h058;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_one_wait: assert property (take |=> pready)
        else $error("answer not one cycle after access");
    a_key_locks: assert property (key_wr && pwdata == `OSL_KEY |=> lock_set)
        else $error("key write did not lock");
    a_other_unlocks: assert property (key_wr && pwdata != `OSL_KEY |=> !lock_set)
        else $error("other value did not unlock");
    a_locked_error: assert property (take && lock_set && bank |=> pready && pslverr)
        else $error("locked bank access without error");
    a_open_ok: assert property (take && !lock_set && bank && paddr[1:0] == 2'b00
        |=> !pslverr)
        else $error("unlocked bank access refused");
    a_status_zeros: assert property (take && !pwrite && paddr == `OSL_STAT_OFF
        |=> prdata[31:1] == {30'h0, lock_set})
        else $error("status upper bits wrong");
    a_present_bit: assert property (take && !pwrite && paddr == `OSL_STAT_OFF
        |=> prdata[0])
        else $error("present bit not set");
    a_lock_stable: assert property (!key_wr |=> $stable(lock_set))
        else $error("lock moved without key access");
    a_strap_init: assert property ($fell(reset) |-> lock_set == lock_init_strap)
        else $error("lock not taken from strap");
endmodule
bind osl_lock osl_lock_chk i_chk (.clk(clk), .reset(reset), .lock_init_strap(lock_init_strap),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_status_control_flags(debug_status_control_flags),
    .lock_set(lock_set));
`default_nettype wire

/* testbench/osl_apb_master.sv */
// APB master model standing in for the debugger or the OS
`timescale 1ns/100ps
`default_nettype none
module osl_apb_master (
    // Clock
    input wire logic clk,
    // Request
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [11:0] paddr,
    output var logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hfff;
        pwdata = 32'h0;
    end
    // Setup, then access held until pready is seen at an edge; whole words only
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk) #1;
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(posedge clk) #1;
        penable = 1'b1;
        n = 0;
        // Bounded wait so a dead slave cannot hang the run
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk) #1;
            n++;
        end
        r = prdata;
        e = (n < 16) ? pslverr : 1'bx;
        @(posedge clk) #1;
        psel = 1'b0;
        penable = 1'b0;
        // Released lines show junk, not the last value
        paddr = ~paddr;
        pwdata = ~pwdata;
    endtask
endmodule
`default_nettype wire

/* testbench/test_osl_lock.sv */
// Self-checking bench for the lock and save/restore block
`timescale 1ns/100ps
`default_nettype none
`include "osl_defs.svh"
module test_osl_lock;
    logic clk, reset, strap, psel, penable, pwrite, pready, pslverr, lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, flags;
    int err_total, cmp_count;
    osl_lock i_dut (.clk(clk), .reset(reset), .lock_init_strap(strap), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_status_control_flags(flags), .lock_set(lock));
    osl_apb_master i_apb (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count and report one comparison
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One access; error flag always checked, data only on reads
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        i_apb.xfer(w, a, d, r, e);
        chk("slave error", {31'h0, xe}, {31'h0, e});
        if (!w) chk("read data", x, r);
    endtask
    // Bank contents: status/control keeps live flags outside mask m
    function automatic logic [31:0] bx(input int i, input logic [31:0] v, input logic [31:0] m);
        return (i == 17) ? ((v & m) | (flags & ~m)) : v;
    endfunction
    // Pattern sets the status/control bits plain writes may change, so a lost write shows
    function automatic logic [31:0] pv(input int i);
        return 32'h5a5ac000 | 32'(i);
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog, well beyond the some 560 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        wrap_up;
    end
    initial begin
        reset = 1'b1;
        strap = 1'b1;
        flags = 32'h12345678;
        err_total = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        chk("lock", 32'h1, {31'h0, lock});
        acc(0, `OSL_STAT_OFF, 0, 32'h3, 0);
        acc(0, 12'h004, 0, 0, 1);
        acc(1, `OSL_STAT_OFF, 0, 0, 0);
        acc(0, `OSL_STAT_OFF, 0, 32'h3, 0);
        acc(1, `OSL_KEY_OFF, 32'hc5acce54, 0, 0);
        acc(0, `OSL_STAT_OFF, 0, 32'h1, 0);
        for (int i = 0; i < 22; i++) acc(1, 12'(4 * i), pv(i), 0, 0);
        for (int i = 0; i < 22; i++)
            acc(0, 12'(4 * i), 0, bx(i, pv(i), `OSL_DEBUG_STATUS_CONTROL_WMASK), 0);
        $display("test access done");
        // Save abandoned after three words, then restarted
        acc(1, `OSL_KEY_OFF, `OSL_KEY, 0, 0);
        chk("lock", 32'h1, {31'h0, lock});
        acc(0, `OSL_SSR_OFF, 0, 32'd22, 0);
        for (int i = 0; i < 3; i++) acc(0, `OSL_SSR_OFF, 0, pv(i), 0);
        acc(1, `OSL_KEY_OFF, `OSL_KEY, 0, 0);
        acc(0, `OSL_SSR_OFF, 0, 32'd22, 0);
        for (int i = 0; i < 22; i++)
            acc(0, `OSL_SSR_OFF, 0, bx(i, pv(i), `OSL_DEBUG_STATUS_CONTROL_WMASK), 0);
        acc(0, `OSL_SSR_OFF, 0, 0, 0);
        $display("test save done");
        // Restore, then unlock and read the bank back
        acc(1, `OSL_KEY_OFF, `OSL_KEY, 0, 0);
        acc(0, `OSL_SSR_OFF, 0, 32'd22, 0);
        for (int i = 0; i < 22; i++) acc(1, `OSL_SSR_OFF, ~pv(i), 0, 0);
        acc(1, `OSL_KEY_OFF, 0, 0, 0);
        for (int i = 0; i < 22; i++)
            acc(0, 12'(4 * i), 0, bx(i, ~pv(i), `OSL_DEBUG_STATUS_CONTROL_WMASK | `OSL_DEBUG_STATUS_CONTROL_RMASK), 0);
        $display("test restore done");
        // Lock, then reset mid-run with the strap low: lock, bank and pointer clear
        acc(1, `OSL_KEY_OFF, `OSL_KEY, 0, 0);
        @(posedge clk) #1;
        reset = 1'b1;
        strap = 1'b0;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        chk("lock", 32'h0, {31'h0, lock});
        acc(0, `OSL_STAT_OFF, 0, 32'h1, 0);
        acc(0, 12'h000, 0, 0, 0);
        acc(0, `OSL_KEY_OFF, 0, 0, 0);
        acc(0, 12'h100, 0, 0, 1);
        acc(0, 12'h002, 0, 0, 1);
        // A port write before the length read must not move the pointer
        acc(1, `OSL_SSR_OFF, 32'h0, 0, 0);
        acc(0, `OSL_SSR_OFF, 0, 32'd22, 0);
        $display("test reset done");
        wrap_up;
    end
endmodule
`default_nettype wire
